/* include/pqm_pkg.sv */
// Package with register map, field layout, reset values and carriers for the queue mapper.
// Overview of operation
// - Each priority code 0..7 maps to queue 0..3 through a software table.
// - Queue 3 is the highest priority, queue 0 the lowest.
// - Offset 0x80 bits 1-0 and 3-2 map codes 0 and 1; reset to queue 0.
// - Offset 0x80 bits 5-4 and 7-6 map codes 2 and 3; reset to queue 1.
// - Offset 0x81 bits 1-0 and 3-2 map codes 4 and 5; reset to queue 2.
// - Offset 0x81 bits 5-4 and 7-6 map codes 6 and 7; reset to queue 3.
// - In two-queue mode the selector at 0x82 bits 7-6 folds the result.
// - The folded result comes from the priority-code or the DiffServ table.
// - In two-queue mode result 0 always goes to the low queue.
// - In two-queue mode result 3 always goes to the high queue.
// - Selector 00: results 0, 1, 2 low; result 3 high.
// - Selector 10, the reset value: results 0, 1 low; 2, 3 high.
// - Selector 11: result 0 low; results 1, 2, 3 high.
package pqm_pkg;
  localparam logic [7:0] ADDR_MAP_LOW = 8'h80;
  localparam logic [7:0] ADDR_MAP_HIGH = 8'h81;
  localparam logic [7:0] ADDR_FOLD_SEL = 8'h82;
  localparam logic [7:0] ADDR_UNK_UC = 8'h83;
  localparam logic [7:0] RST_MAP_LOW = 8'h50;
  localparam logic [7:0] RST_MAP_HIGH = 8'hfa;
  localparam logic [1:0] RST_FOLD_SEL = 2'h2;
  localparam logic [5:0] FOLD_RSVD = 6'h08;
  localparam logic [1:0] UNK_UC_RSVD = 2'h2;
  localparam int FOLD_SEL_LSB = 6;
  localparam int UNK_UC_EN_BIT = 5;
  localparam int READ_LATENCY = 1;
  localparam logic [1:0] QUEUE_LOWEST = 2'h0;
  localparam logic [1:0] QUEUE_HIGHEST = 2'h3;

  // Fold selector encodings.
  localparam logic [1:0] FOLD_ONLY_TOP = 2'h0;
  localparam logic [1:0] FOLD_UNSUPPORTED = 2'h1;
  localparam logic [1:0] FOLD_HALF = 2'h2;
  localparam logic [1:0] FOLD_ALL_BUT_ZERO = 2'h3;

  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } pqm_bus_req_t;

  typedef struct packed {
    logic valid;
    logic use_diffserv;
    logic [2:0] pcp;
    logic [1:0] diffserv_level;
  } pqm_frame_t;

  typedef struct packed {
    logic valid;
    logic [1:0] queue;
    logic high;
  } pqm_result_t;
endpackage

/* logic/pqm_fold.sv */
// Two-queue fold of a four-level priority result.
`timescale 1ns/100ps
module pqm_fold (
  // Fold control
  input wire logic [1:0] fold_sel,
  // Four-level result in, queue half out
  input wire logic [1:0] level,
  output logic high
);
  always_comb begin
    unique case (fold_sel)
      pqm_pkg::FOLD_ONLY_TOP: high = (level == pqm_pkg::QUEUE_HIGHEST);
      pqm_pkg::FOLD_HALF: high = level[1];
      pqm_pkg::FOLD_ALL_BUT_ZERO: high = (level != pqm_pkg::QUEUE_LOWEST);
      // Unsupported setting behaves as the half fold and still keeps the two fixed ends.
      pqm_pkg::FOLD_UNSUPPORTED: high = level[1];
    endcase
  end
endmodule

/* logic/pqm_mapper.sv */
// Priority code to egress queue mapper with its control registers.
`timescale 1ns/100ps
module pqm_mapper (
  // Clock, reset and enable
  input wire logic core_clk,
  input wire logic srst,
  input wire logic clk_en,
  // Register port
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  // Operating mode
  input wire logic two_queue_mode,
  // Frame classification in
  input wire logic frame_valid,
  input wire logic [2:0] frame_pcp,
  input wire logic frame_use_diffserv,
  input wire logic [1:0] frame_diffserv_level,
  // Queue result and unknown unicast control out
  output logic queue_valid,
  output logic [1:0] queue_index,
  output logic queue_high,
  output logic [7:0] unknown_unicast_ctrl
);
  logic [7:0] map_low;
  logic [7:0] map_high;
  logic [1:0] fold_sel;
  logic [5:0] unk_uc;
  logic [15:0] table_bits;
  logic [1:0] pcp_level;
  logic [1:0] level;
  logic fold_high;
  logic [1:0] next_queue;
  pqm_pkg::pqm_frame_t frame;
  pqm_pkg::pqm_result_t result;
  pqm_pkg::pqm_result_t next_result;
  pqm_pkg::pqm_bus_req_t bus_req;
  logic wr_map_low;
  logic wr_map_high;
  logic wr_fold_sel;
  logic wr_unk_uc;
  logic [7:0] code_hit;
  logic [1:0] code_level [8];

  // Whole table after reset, field n at bits 2n+1..2n, for the per-entry checks.
  localparam logic [15:0] RESET_TABLE = {pqm_pkg::RST_MAP_HIGH, pqm_pkg::RST_MAP_LOW};
  // Reference fold: bit n says whether result n goes high; selector 01 acts as 10.
  localparam logic [3:0] FOLD_REF [4] = '{4'b1000, 4'b1100, 4'b1100, 4'b1110};

  assign frame = '{valid: frame_valid, use_diffserv: frame_use_diffserv,
                   pcp: frame_pcp, diffserv_level: frame_diffserv_level};

  // One carrier for the register port keeps the decode in a single place.
  assign bus_req = '{addr: reg_addr, wdata: reg_wdata, wr: reg_wr, rd: reg_rd};

  // Write strobes carry the enable, so a frozen block ignores software as well.
  assign wr_map_low = clk_en && bus_req.wr && (bus_req.addr == pqm_pkg::ADDR_MAP_LOW);
  assign wr_map_high = clk_en && bus_req.wr && (bus_req.addr == pqm_pkg::ADDR_MAP_HIGH);
  assign wr_fold_sel = clk_en && bus_req.wr && (bus_req.addr == pqm_pkg::ADDR_FOLD_SEL);
  assign wr_unk_uc = clk_en && bus_req.wr && (bus_req.addr == pqm_pkg::ADDR_UNK_UC);

  // Low half of the mapping table, codes 0 to 3.
  always_ff @(posedge core_clk) begin
    if (srst) begin
      map_low <= pqm_pkg::RST_MAP_LOW;
    end else if (wr_map_low) begin
      map_low <= bus_req.wdata;
    end
  end

  // High half of the mapping table, codes 4 to 7.
  always_ff @(posedge core_clk) begin
    if (srst) begin
      map_high <= pqm_pkg::RST_MAP_HIGH;
    end else if (wr_map_high) begin
      map_high <= bus_req.wdata;
    end
  end

  // Fold selector; its reserved neighbours are constants and never stored.
  always_ff @(posedge core_clk) begin
    if (srst) begin
      fold_sel <= pqm_pkg::RST_FOLD_SEL;
    end else if (wr_fold_sel) begin
      fold_sel <= bus_req.wdata[7:6];
    end
  end

  // Unknown unicast control keeps only its writable low six bits.
  always_ff @(posedge core_clk) begin
    if (srst) begin
      unk_uc <= 6'h00;
    end else if (wr_unk_uc) begin
      unk_uc <= bus_req.wdata[5:0];
    end
  end

  // Read data stands in the cycle after the strobe only; unmapped reads give zero.
  always_ff @(posedge core_clk) begin
    if (srst) begin
      reg_rdata <= 8'h00;
    end else if (clk_en) begin
      if (bus_req.rd) begin
        unique case (bus_req.addr)
          pqm_pkg::ADDR_MAP_LOW: reg_rdata <= map_low;
          pqm_pkg::ADDR_MAP_HIGH: reg_rdata <= map_high;
          pqm_pkg::ADDR_FOLD_SEL: reg_rdata <= {fold_sel, pqm_pkg::FOLD_RSVD};
          pqm_pkg::ADDR_UNK_UC: reg_rdata <= {pqm_pkg::UNK_UC_RSVD, unk_uc};
          default: reg_rdata <= 8'h00;
        endcase
      end else begin
        reg_rdata <= 8'h00;
      end
    end
  end

  assign unknown_unicast_ctrl = {pqm_pkg::UNK_UC_RSVD, unk_uc};

  // Field n of the 16-bit table sits at bits 2n+1..2n.
  assign table_bits = {map_high, map_low};

  // Per code: a match flag and that code's two-bit field of the table.
  for (genvar g = 0; g < 8; g++) begin : g_code
    assign code_hit[g] = (frame.pcp == 3'(g));
    assign code_level[g] = table_bits[2*g +: 2];
    a_entry_reset: assert property (@(posedge core_clk)
      $past(srst) |-> code_level[g] == RESET_TABLE[2*g +: 2])
      else $error("mapping entry reset value wrong");
    a_entry_select: assert property (@(posedge core_clk) disable iff (srst)
      clk_en && !two_queue_mode && !frame_use_diffserv && frame_pcp == 3'(g) |=>
      queue_index == $past(code_level[g]))
      else $error("mapping entry not applied");
  end

  // The codes are exclusive, so at most one field passes to the result.
  always_comb begin
    pcp_level = 2'h0;
    for (int i = 0; i < 8; i++) begin
      if (code_hit[i]) begin
        pcp_level = code_level[i];
      end
    end
  end

  // The DiffServ table lives outside; its level arrives on the frame input.
  assign level = frame.use_diffserv ? frame.diffserv_level : pcp_level;

  pqm_fold u_fold (
    .fold_sel(fold_sel),
    .level(level),
    .high(fold_high)
  );

  // Two-queue mode maps low to queue 0 and high to queue 3, keeping 3 as the top.
  always_comb begin
    if (two_queue_mode) begin
      next_queue = fold_high ? pqm_pkg::QUEUE_HIGHEST : pqm_pkg::QUEUE_LOWEST;
    end else begin
      next_queue = level;
    end
  end

  // The high flag follows the fold only in two-queue mode, else the index's top bit.
  always_comb begin
    next_result.valid = frame.valid;
    next_result.queue = next_queue;
    next_result.high = two_queue_mode ? fold_high : next_queue[1];
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      result <= '0;
    end else if (clk_en) begin
      result <= next_result;
    end
  end

  assign queue_valid = result.valid;
  assign queue_index = result.queue;
  assign queue_high = result.high;

  a_reset_table: assert property (@(posedge core_clk)
    $past(srst) |-> map_low == 8'h50 && map_high == 8'hfa)
    else $error("mapping table reset value wrong");
  a_reset_fold: assert property (@(posedge core_clk)
    $past(srst) |-> fold_sel == 2'h2 && reg_rdata == 8'h00)
    else $error("fold selector reset value wrong");
  a_four_queue_map: assert property (@(posedge core_clk) disable iff (srst)
    clk_en && !two_queue_mode && !frame_use_diffserv |=>
    queue_index == $past(table_bits[{frame_pcp, 1'b0} +: 2]))
    else $error("four-queue index not from table");
  a_level_zero_low: assert property (@(posedge core_clk) disable iff (srst)
    clk_en && two_queue_mode && level == 2'h0 |=> queue_index == 2'h0)
    else $error("result zero not in low queue");
  a_level_three_high: assert property (@(posedge core_clk) disable iff (srst)
    clk_en && two_queue_mode && level == 2'h3 |=> queue_index == 2'h3)
    else $error("result three not in high queue");
  a_fold_half: assert property (@(posedge core_clk) disable iff (srst)
    clk_en && two_queue_mode && fold_sel == 2'h2 |=> queue_high == $past(level[1]))
    else $error("half fold wrong");
  a_fold_top: assert property (@(posedge core_clk) disable iff (srst)
    clk_en && two_queue_mode && fold_sel == 2'h0 && level == 2'h2 |=> !queue_high)
    else $error("top-only fold wrong");
  a_fold_most: assert property (@(posedge core_clk) disable iff (srst)
    clk_en && two_queue_mode && fold_sel == 2'h3 && level == 2'h1 |=> queue_high)
    else $error("all-but-zero fold wrong");
  a_diffserv_source: assert property (@(posedge core_clk) disable iff (srst)
    clk_en && !two_queue_mode && frame_use_diffserv |=>
    queue_index == $past(frame_diffserv_level))
    else $error("diffserv level not used");
  a_reserved_read: assert property (@(posedge core_clk) disable iff (srst)
    clk_en && reg_rd && reg_addr == 8'h82 |=> reg_rdata[5:0] == 6'h08)
    else $error("reserved bits read wrong");
  a_write_readback: assert property (@(posedge core_clk) disable iff (srst)
    clk_en && reg_wr && reg_addr == 8'h80 ##1 clk_en && reg_rd && reg_addr == 8'h80
    |=> reg_rdata == $past(reg_wdata, 2))
    else $error("table write not read back");

  // Reset values of the outputs.
  a_result_reset: assert property (@(posedge core_clk)
    $past(srst) |-> !queue_valid && queue_index == 2'h0 && !queue_high)
    else $error("result not cleared by reset");
  a_unk_reset: assert property (@(posedge core_clk)
    $past(srst) |-> unknown_unicast_ctrl == 8'h80)
    else $error("unknown unicast reset value wrong");

  // The enable freezes every register and the result, not only the table.
  a_freeze_regs: assert property (@(posedge core_clk) disable iff (srst)
    !clk_en |=> map_low == $past(map_low) && map_high == $past(map_high)
    && fold_sel == $past(fold_sel) && unk_uc == $past(unk_uc))
    else $error("register moved while frozen");
  a_freeze_out: assert property (@(posedge core_clk) disable iff (srst)
    !clk_en |=> queue_valid == $past(queue_valid) && queue_index == $past(queue_index)
    && queue_high == $past(queue_high) && reg_rdata == $past(reg_rdata))
    else $error("output moved while frozen");

  // Register port.
  a_read_pulse: assert property (@(posedge core_clk) disable iff (srst)
    clk_en && !reg_rd |=> reg_rdata == 8'h00)
    else $error("read data stood too long");
  a_unmapped_read: assert property (@(posedge core_clk) disable iff (srst)
    clk_en && reg_rd && (reg_addr < 8'h80 || reg_addr > 8'h83) |=> reg_rdata == 8'h00)
    else $error("unmapped read not zero");
  a_read_low: assert property (@(posedge core_clk) disable iff (srst)
    clk_en && reg_rd && reg_addr == 8'h80 |=> reg_rdata == $past(map_low))
    else $error("low table read wrong");
  a_read_high: assert property (@(posedge core_clk) disable iff (srst)
    clk_en && reg_rd && reg_addr == 8'h81 |=> reg_rdata == $past(map_high))
    else $error("high table read wrong");
  a_read_fold: assert property (@(posedge core_clk) disable iff (srst)
    clk_en && reg_rd && reg_addr == 8'h82 |=> reg_rdata == {$past(fold_sel), 6'h08})
    else $error("fold selector read wrong");
  a_read_unk: assert property (@(posedge core_clk) disable iff (srst)
    clk_en && reg_rd && reg_addr == 8'h83 |=> reg_rdata == {2'h2, $past(unk_uc)})
    else $error("unknown unicast read wrong");
  a_write_low: assert property (@(posedge core_clk) disable iff (srst)
    clk_en && reg_wr && reg_addr == 8'h80 |=> map_low == $past(reg_wdata))
    else $error("low table write lost");
  a_write_high: assert property (@(posedge core_clk) disable iff (srst)
    clk_en && reg_wr && reg_addr == 8'h81 |=> map_high == $past(reg_wdata))
    else $error("high table write lost");
  a_fold_write: assert property (@(posedge core_clk) disable iff (srst)
    clk_en && reg_wr && reg_addr == 8'h82 |=> fold_sel == $past(reg_wdata[7:6]))
    else $error("fold selector write lost");
  a_unk_write: assert property (@(posedge core_clk) disable iff (srst)
    clk_en && reg_wr && reg_addr == 8'h83 |=>
    unknown_unicast_ctrl == {2'h2, $past(reg_wdata[5:0])})
    else $error("unknown unicast write wrong");
  a_table_steady: assert property (@(posedge core_clk) disable iff (srst)
    !(clk_en && reg_wr && (reg_addr == 8'h80 || reg_addr == 8'h81)) |=>
    map_low == $past(map_low) && map_high == $past(map_high))
    else $error("table changed without a write");
  a_fold_steady: assert property (@(posedge core_clk) disable iff (srst)
    !(clk_en && reg_wr && reg_addr == 8'h82) |=> fold_sel == $past(fold_sel))
    else $error("fold selector changed without a write");

  // Result path.
  a_valid_follow: assert property (@(posedge core_clk) disable iff (srst)
    clk_en |=> queue_valid == $past(frame_valid))
    else $error("queue valid does not follow frame");
  a_two_queue_ends: assert property (@(posedge core_clk) disable iff (srst)
    clk_en && two_queue_mode |=> queue_index == 2'h0 || queue_index == 2'h3)
    else $error("two-queue index not an end queue");
  a_four_queue_high: assert property (@(posedge core_clk) disable iff (srst)
    clk_en && !two_queue_mode |=> queue_high == queue_index[1])
    else $error("four-queue high flag wrong");
  a_diffserv_fold: assert property (@(posedge core_clk) disable iff (srst)
    clk_en && two_queue_mode && frame_use_diffserv && fold_sel == 2'h2 |=>
    queue_high == $past(frame_diffserv_level[1]))
    else $error("diffserv level not folded");
  for (genvar lv = 0; lv < 4; lv++) begin : g_fold_ref
    a_fold_level: assert property (@(posedge core_clk) disable iff (srst)
      clk_en && two_queue_mode && level == 2'(lv) |=>
      queue_high == $past(FOLD_REF[fold_sel][lv]))
      else $error("fold of a result level wrong");
  end

  c_two_queue: cover property (@(posedge core_clk) two_queue_mode && frame_valid && fold_high);
  c_diffserv: cover property (@(posedge core_clk) frame_valid && frame_use_diffserv);
  c_table_write: cover property (@(posedge core_clk) reg_wr && reg_addr == 8'h81);
  c_fold_change: cover property (@(posedge core_clk) reg_wr && reg_addr == 8'h82);
  c_frozen_write: cover property (@(posedge core_clk) !clk_en && reg_wr);
endmodule

/* tb/pqm_tb.sv */
// Self-checking bench for the priority code to queue mapper.
`timescale 1ns/100ps
module testbench;
  logic core_clk = 1'b0;
  logic srst = 1'b1;
  logic clk_en = 1'b1;
  logic [7:0] reg_addr = 8'h00;
  logic [7:0] reg_wdata = 8'h00;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic two_queue_mode = 1'b0;
  logic frame_valid = 1'b0;
  logic [2:0] frame_pcp = 3'h0;
  logic frame_use_diffserv = 1'b0;
  logic [1:0] frame_diffserv_level = 2'h0;
  logic [7:0] reg_rdata;
  logic queue_valid;
  logic [1:0] queue_index;
  logic queue_high;
  logic [7:0] unknown_unicast_ctrl;
  logic hi;
  logic [1:0] lv;
  int mismatches = 0;
  int total_checks = 0;
  // Row: mode, diffserv, pcp, level, queue, high; reset map and reset fold selector.
  logic [9:0] rows [16] = '{
    10'b0_0_000_00_00_0, 10'b0_0_001_00_00_0, 10'b0_0_010_00_01_0, 10'b0_0_011_00_01_0,
    10'b0_0_100_00_10_1, 10'b0_0_101_00_10_1, 10'b0_0_110_00_11_1, 10'b0_0_111_00_11_1,
    10'b1_0_001_00_00_0, 10'b1_0_011_00_00_0, 10'b1_0_100_00_11_1, 10'b1_0_110_00_11_1,
    10'b0_1_111_00_00_0, 10'b0_1_111_01_01_0, 10'b0_1_000_10_10_1, 10'b0_1_000_11_11_1};

  always #25 core_clk = ~core_clk;

  pqm_mapper dut_u (
    .core_clk, .srst, .clk_en, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
    .two_queue_mode, .frame_valid, .frame_pcp, .frame_use_diffserv, .frame_diffserv_level,
    .queue_valid, .queue_index, .queue_high, .unknown_unicast_ctrl
  );

  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    total_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // The wr, rd and frm tasks start just after a rising edge and end just after one.
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge core_clk);
    reg_wr <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    @(negedge core_clk);
    chk(reg_rdata, e);
    @(posedge core_clk);
  endtask

  task automatic frm(input logic m, input logic ds, input logic [2:0] p, input logic [1:0] l,
                     input logic [1:0] q, input logic h);
    two_queue_mode <= m;
    frame_use_diffserv <= ds;
    frame_pcp <= p;
    frame_diffserv_level <= l;
    frame_valid <= 1'b1;
    @(posedge core_clk);
    frame_valid <= 1'b0;
    @(negedge core_clk);
    chk({7'h00, queue_valid}, 8'h01);
    chk({5'h00, queue_index, queue_high}, {5'h00, q, h});
    @(posedge core_clk);
  endtask

  task automatic print_verdict;
    if (mismatches == 0 && total_checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  // The whole sequence needs well under a thousand cycles.
  initial begin
    #200000;
    mismatches++;
    print_verdict();
  end

  initial begin
    repeat (16) @(posedge core_clk);
    srst <= 1'b0;
    rd(8'h80, 8'h50);
    rd(8'h81, 8'hfa);
    rd(8'h82, 8'h88);
    rd(8'h83, 8'h80);
    // Read data stands for one cycle only.
    @(negedge core_clk);
    chk(reg_rdata, 8'h00);
    @(posedge core_clk);
    rd(8'h7f, 8'h00);
    for (int i = 0; i < 16; i++)
      frm(rows[i][9], rows[i][8], rows[i][7:5], rows[i][4:3], rows[i][2:1], rows[i][0]);
    @(negedge core_clk);
    chk({7'h00, queue_valid}, 8'h00);
    @(posedge core_clk);
    wr(8'h80, 8'h1b);
    rd(8'h80, 8'h1b);
    wr(8'h81, 8'he4);
    rd(8'h81, 8'he4);
    for (int m = 0; m < 2; m++) begin
      for (int p = 0; p < 8; p++) begin
        lv = 2'(p < 4 ? 3 - p : p - 4);
        hi = (lv >= 2'h2);
        frm(m[0], 1'b0, 3'(p), 2'h0, m[0] ? (hi ? 2'h3 : 2'h0) : lv, m[0] ? hi : lv[1]);
      end
    end
    for (int s = 0; s < 4; s++) begin
      // Software never programs the unsupported selector setting.
      if (s == 1) continue;
      wr(8'h82, {2'(s), 6'h37});
      rd(8'h82, {2'(s), 6'h08});
      for (int l = 0; l < 4; l++) begin
        hi = (s == 0) ? (l == 3) : ((s == 3) ? (l != 0) : (l >= 2));
        frm(1'b1, 1'b1, 3'h7, 2'(l), hi ? 2'h3 : 2'h0, hi);
      end
    end
    wr(8'h83, 8'hff);
    rd(8'h83, 8'hbf);
    chk(unknown_unicast_ctrl, 8'hbf);
    wr(8'h84, 8'hff);
    rd(8'h84, 8'h00);
    srst <= 1'b1;
    @(posedge core_clk);
    srst <= 1'b0;
    rd(8'h80, 8'h50);
    rd(8'h82, 8'h88);
    chk(unknown_unicast_ctrl, 8'h80);
    // A frozen block must ignore a write.
    clk_en <= 1'b0;
    wr(8'h80, 8'hff);
    clk_en <= 1'b1;
    rd(8'h80, 8'h50);
    print_verdict();
  end
endmodule
